// >>> yag_cfg.svh
// Constants for the remote alarm generator: offsets, fields, reset values, timing
//
// Operation
// - Format code 00 sends no alarm and leaves frames untouched.
// - Code 01 in SF or N framing clears bit 2 of every DS0 channel.
// - Data-mode framing with code 01 or 10 clears the sync byte Y-bit.
// - Code 01 in ESF sends 255 patterns of eight ones, eight zeros.
// - ESF request sets duration; a short request still yields all 255 patterns.
// - Request still high at burst end restarts count for another 255 patterns.
// - After a code 01 or 11 burst ends with the request low, ESF waits at least one second before the next.
// - Code 10 in SF framing sets the frame 12 Fs bit to one.
// - J1 ESF setting inserts SF, N and data-mode alarms like code 01.
// - J1 ESF setting in ESF uses code 01 timing but all-ones patterns.
// - The all-ones ESF pattern is sixteen consecutive one bits.
`ifndef YAG_CFG_SVH
`define YAG_CFG_SVH

// ****************************************
// Register map (byte addresses)
// ****************************************
`define YAG_ADDR_CTRL 12'h000
`define YAG_ADDR_STATUS 12'h004
`define YAG_ADDR_W 12

// ****************************************
// Control register fields and reset value
// ****************************************
`define YAG_CTRL_FRAMING_LSB 0
`define YAG_CTRL_FMT_LSB 4
`define YAG_CTRL_REQ_BIT 6
`define YAG_CTRL_RESET 7'h00

// ****************************************
// Format codes
// ****************************************
`define YAG_FMT_OFF 2'h0
`define YAG_FMT_STD 2'h1
`define YAG_FMT_ALT 2'h2
`define YAG_FMT_J1ESF 2'h3

// ****************************************
// Data link pattern and timing
// ****************************************
`define YAG_BURST_PATTERNS 255
`define YAG_PATTERN_BITS 16
`define YAG_HOLDOFF_MS 1000
`define YAG_CLK_MHZ 250
`define YAG_HOLDOFF_CYCLES (`YAG_HOLDOFF_MS * 1000 * `YAG_CLK_MHZ)

`endif

// >>> yag_esf_pattern.sv
// Data link alarm pattern source: 16-bit pattern bit counter with burst counter
`timescale 1ns/10ps
`default_nettype none
`include "yag_cfg.svh"

module yag_esf_pattern #(
  parameter int unsigned PATTERNS = `YAG_BURST_PATTERNS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // Control
  input wire logic start,
  input wire logic all_ones,
  input wire logic fdl_strobe,
  // Result
  output logic pat_bit,
  output logic burst_done,
  output logic [7:0] pat_count
);

  logic [3:0] bit_idx_ff;
  logic [3:0] nxt_bit_idx;
  logic [7:0] pat_cnt_ff;
  logic [7:0] nxt_pat_cnt;
  logic last_bit;

  assign last_bit = (bit_idx_ff == 4'(`YAG_PATTERN_BITS - 1));
  // First eight bits of each pattern are ones, the rest zeros unless all-ones
  assign pat_bit = all_ones | ~bit_idx_ff[3];
  assign burst_done = fdl_strobe & last_bit & (pat_cnt_ff == 8'(PATTERNS - 1));
  assign pat_count = pat_cnt_ff;

  always_comb begin
    nxt_bit_idx = bit_idx_ff;
    nxt_pat_cnt = pat_cnt_ff;
    if (start) begin
      nxt_bit_idx = 4'h0;
      nxt_pat_cnt = 8'h00;
    end else if (fdl_strobe) begin
      nxt_bit_idx = bit_idx_ff + 4'h1;
      if (last_bit) begin
        nxt_pat_cnt = burst_done ? 8'h00 : pat_cnt_ff + 8'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_idx_ff <= 4'h0;
      pat_cnt_ff <= 8'h00;
    end else if (ce) begin
      bit_idx_ff <= nxt_bit_idx;
      pat_cnt_ff <= nxt_pat_cnt;
    end
  end

endmodule
`default_nettype wire

// >>> yag_line_model.sv
// Remote terminal model: counts line bits it receives
`timescale 1ns/10ps
`default_nettype none

module yag_line_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Line side
  input wire logic bit_valid_out,
  input wire logic bit_out,
  // Received count
  output logic [15:0] rx_count
);
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rx_count <= 16'h0000;
    end else if (bit_valid_out) begin
      rx_count <= rx_count + 16'h0001;
    end
  end
endmodule

`default_nettype wire

// >>> yag_monitor.sv
// Checker for the remote alarm generator ports
`timescale 1ns/10ps
`default_nettype none
`include "yag_cfg.svh"

module yag_mon
  import yag_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = `YAG_HOLDOFF_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  // Stream
  input wire logic bit_valid_in,
  input wire logic bit_in,
  input wire logic ds0_bit2_slot,
  input wire logic fs_frame12_slot,
  input wire logic fdl_slot,
  input wire logic dm_ybit_slot,
  input wire logic bit_out,
  input wire logic alarm_active
);
  logic wp_ff;
  logic [31:0] quiet_ff;
  logic [6:0] ctl_ff;
  logic [1:0] fr;
  logic [1:0] fm;
  logic esf;
  assign fr = ctl_ff[1:0];
  assign fm = ctl_ff[5:4];
  assign esf = fr == YAG_FR_ESF;
  // ********
  // Control shadow, rebuilt from bus writes so no design internals are needed
  // ********
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wp_ff <= 1'b0;
      quiet_ff <= 32'h0000_0000;
      ctl_ff <= 7'h00;
    end else begin
      wp_ff <= hsel & htrans[1] & hwrite & hready & (haddr[11:0] == 12'h000);
      // Cycles since the alarm was last shown, saturating
      if (alarm_active) begin
        quiet_ff <= 32'h0000_0000;
      end else if (quiet_ff != 32'hFFFF_FFFF) begin
        quiet_ff <= quiet_ff + 32'h0000_0001;
      end
      if (wp_ff) begin
        ctl_ff <= hwdata[6:0];
      end
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_off;
    fm == 2'h0 |=> bit_out == $past(bit_in);
  endproperty
  a_off: assert property (p_off) else $error("bit altered with alarm off");
  property p_ds0;
    fm[0] && !fr[0] && ds0_bit2_slot |=> !bit_out;
  endproperty
  a_ds0: assert property (p_ds0) else $error("channel bit not cleared");
  property p_ybit;
    fm != 2'h0 && fr == YAG_FR_DM && dm_ybit_slot |=> !bit_out;
  endproperty
  a_ybit: assert property (p_ybit) else $error("sync bit not cleared");
  property p_fs;
    fm == 2'h2 && fr == YAG_FR_SF && fs_frame12_slot |=> bit_out;
  endproperty
  a_fs: assert property (p_fs) else $error("frame bit not set");
  property p_ones;
    fm == 2'h3 && esf && bit_valid_in && fdl_slot && alarm_active ##1 alarm_active |-> bit_out;
  endproperty
  a_ones: assert property (p_ones) else $error("link bit not one");
  property p_c10on;
    // A holdoff left by an earlier timed burst may still delay the start
    $rose(ctl_ff[6]) && fm == 2'h2 && esf && quiet_ff > HOLDOFF_CYCLES + 4
      |-> ##[1:4] alarm_active;
  endproperty
  a_c10on: assert property (p_c10on) else $error("alarm did not start");
  property p_c10off;
    $fell(ctl_ff[6]) && fm == 2'h2 && esf |-> ##[1:4] !alarm_active;
  endproperty
  a_c10off: assert property (p_c10off) else $error("alarm did not stop");
  property p_hold;
    // Only a drop inside a settled timed mode is a burst end
    $fell(alarm_active) && esf && fm[0] && $past(esf, 2) && $past(fm[0], 2)
      |-> !alarm_active [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("alarm restarted early");
  property p_min;
    $rose(alarm_active) && esf && fm[0] |-> alarm_active [*8];
  endproperty
  a_min: assert property (p_min) else $error("burst too short");
  c_burst: cover property ($rose(alarm_active) && esf && fm == 2'h1);
  c_ones: cover property (alarm_active && esf && fm == 2'h3);
  c_cont: cover property ($fell(alarm_active) && esf && fm == 2'h2);
endmodule

bind yag_top yag_mon #(.HOLDOFF_CYCLES(HOLDOFF_CYCLES)) u_mon (.clk, .rst_b, .hsel,
  .haddr, .htrans, .hwrite, .hready,
  .hwdata, .bit_valid_in, .bit_in, .ds0_bit2_slot, .fs_frame12_slot, .fdl_slot,
  .dm_ybit_slot, .bit_out, .alarm_active);

`default_nettype wire

// >>> yag_pkg.sv
// Types shared by the remote alarm generator modules
package yag_pkg;

  typedef enum logic [1:0] {
    YAG_IDLE = 2'b00,
    YAG_SEND = 2'b01,
    YAG_HOLD = 2'b11,
    YAG_CONT = 2'b10
  } yag_state_e;

  typedef enum logic [1:0] {
    YAG_FR_SF = 2'b00,
    YAG_FR_ESF = 2'b01,
    YAG_FR_N = 2'b10,
    YAG_FR_DM = 2'b11
  } yag_framing_e;

endpackage

// >>> yag_top.sv
// Remote alarm generator: AHB-Lite registers, ESF burst control and bit insertion
//
// Implementation choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
`include "yag_cfg.svh"

module yag_top
  import yag_pkg::*;
#(
  parameter int unsigned HOLDOFF_CYCLES = `YAG_HOLDOFF_CYCLES,
  parameter int unsigned PATTERNS = `YAG_BURST_PATTERNS
) (
  // Clock, reset and enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Outgoing bit stream from the framer
  input wire logic bit_valid_in,
  input wire logic bit_in,
  input wire logic ds0_bit2_slot,
  input wire logic fs_frame12_slot,
  input wire logic fdl_slot,
  input wire logic dm_ybit_slot,
  // Modified bit stream toward the line
  output logic bit_valid_out,
  output logic bit_out,
  output logic alarm_active
);

  // ****************************************
  // Control register decoding
  // ****************************************
  function automatic logic [1:0] fmt_of(input logic [6:0] c);
    fmt_of = c[`YAG_CTRL_FMT_LSB +: 2];
  endfunction

  function automatic yag_framing_e framing_of(input logic [6:0] c);
    framing_of = yag_framing_e'(c[`YAG_CTRL_FRAMING_LSB +: 2]);
  endfunction

  logic [6:0] ctrl_ff;
  logic [6:0] nxt_ctrl;
  logic [1:0] rai_format_select;
  logic alarm_request;
  yag_framing_e framing;

  assign rai_format_select = fmt_of(ctrl_ff);
  assign framing = framing_of(ctrl_ff);
  assign alarm_request = ctrl_ff[`YAG_CTRL_REQ_BIT];

  // ****************************************
  // AHB-Lite slave
  // ****************************************
  logic dph_wr_ff;
  logic nxt_dph_wr;
  logic [`YAG_ADDR_W-1:0] dph_addr_ff;
  logic [`YAG_ADDR_W-1:0] nxt_dph_addr;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic hreadyout_ff;
  logic hresp_ff;
  logic addr_phase;
  logic wr_ctrl;
  logic [6:0] ctrl_view;
  logic [31:0] status_word;

  assign addr_phase = hsel & htrans[1] & hready;
  assign wr_ctrl = dph_wr_ff & (dph_addr_ff == `YAG_ADDR_CTRL);
  // A read right behind a write to the same register sees the new value
  assign ctrl_view = wr_ctrl ? hwdata[6:0] : ctrl_ff;

  always_comb begin
    nxt_dph_wr = 1'b0;
    nxt_dph_addr = dph_addr_ff;
    nxt_hrdata = 32'h0000_0000;
    nxt_ctrl = wr_ctrl ? hwdata[6:0] : ctrl_ff;
    if (addr_phase) begin
      nxt_dph_wr = hwrite;
      nxt_dph_addr = haddr[`YAG_ADDR_W-1:0];
      if (!hwrite) begin
        case (haddr[`YAG_ADDR_W-1:0])
          `YAG_ADDR_CTRL: begin
            nxt_hrdata = {25'h000_0000, ctrl_view};
          end
          `YAG_ADDR_STATUS: begin
            nxt_hrdata = status_word;
          end
          default: begin
            nxt_hrdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      dph_wr_ff <= 1'b0;
      dph_addr_ff <= `YAG_ADDR_CTRL;
      hrdata_ff <= 32'h0000_0000;
      hreadyout_ff <= 1'b0;
      hresp_ff <= 1'b0;
      ctrl_ff <= `YAG_CTRL_RESET;
    end else if (ce) begin
      dph_wr_ff <= nxt_dph_wr;
      dph_addr_ff <= nxt_dph_addr;
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      ctrl_ff <= nxt_ctrl;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;

  // ****************************************
  // ESF alarm sequencing
  // ****************************************
  yag_state_e state_ff;
  yag_state_e nxt_state;
  logic pending_ff;
  logic nxt_pending;
  logic req_prev_ff;
  logic nxt_req_prev;
  logic [31:0] hold_cnt_ff;
  logic [31:0] nxt_hold_cnt;
  logic esf_mode;
  logic burst_fmt;
  logic start_burst;
  logic burst_done;
  logic fdl_strobe;
  logic pat_bit;
  logic [7:0] pat_count;

  assign esf_mode = (framing == YAG_FR_ESF);
  // Codes 01 and 11 share the timed burst; only the pattern differs
  assign burst_fmt = (rai_format_select == `YAG_FMT_STD)
                   | (rai_format_select == `YAG_FMT_J1ESF);
  assign fdl_strobe = bit_valid_in & fdl_slot;

  always_comb begin
    nxt_state = state_ff;
    nxt_hold_cnt = hold_cnt_ff;
    start_burst = 1'b0;
    nxt_req_prev = alarm_request;
    case (state_ff)
      YAG_IDLE: begin
        if (esf_mode && burst_fmt && pending_ff) begin
          nxt_state = YAG_SEND;
          start_burst = 1'b1;
        end else if (esf_mode && rai_format_select == `YAG_FMT_ALT && alarm_request) begin
          nxt_state = YAG_CONT;
          start_burst = 1'b1;
        end
      end
      YAG_SEND: begin
        if (!esf_mode || !burst_fmt) begin
          nxt_state = YAG_IDLE;
        end else if (burst_done) begin
          if (alarm_request) begin
            start_burst = 1'b1;
          end else begin
            nxt_state = YAG_HOLD;
            nxt_hold_cnt = HOLDOFF_CYCLES;
          end
        end
      end
      YAG_CONT: begin
        // Ends as soon as the request drops, even mid-pattern
        if (!alarm_request || !esf_mode || rai_format_select != `YAG_FMT_ALT) begin
          nxt_state = YAG_IDLE;
        end
      end
      YAG_HOLD: begin
        if (hold_cnt_ff <= 32'h0000_0001) begin
          nxt_state = YAG_IDLE;
          nxt_hold_cnt = 32'h0000_0000;
        end else begin
          nxt_hold_cnt = hold_cnt_ff - 32'h0000_0001;
        end
      end
      default: begin
        nxt_state = YAG_IDLE;
      end
    endcase
    // A request edge is remembered so a brief pulse is never lost; set wins
    nxt_pending = (alarm_request & ~req_prev_ff) | (pending_ff & ~start_burst);
    if (!esf_mode || !burst_fmt) begin
      nxt_pending = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= YAG_IDLE;
      pending_ff <= 1'b0;
      req_prev_ff <= 1'b0;
      hold_cnt_ff <= 32'h0000_0000;
    end else if (ce) begin
      state_ff <= nxt_state;
      pending_ff <= nxt_pending;
      req_prev_ff <= nxt_req_prev;
      hold_cnt_ff <= nxt_hold_cnt;
    end
  end

  yag_esf_pattern #(
    .PATTERNS(PATTERNS)
  ) u_pattern (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .start(start_burst),
    .all_ones(rai_format_select == `YAG_FMT_J1ESF),
    .fdl_strobe(fdl_strobe),
    .pat_bit(pat_bit),
    .burst_done(burst_done),
    .pat_count(pat_count)
  );

  assign status_word = {16'h0000, pat_count, 4'h0, (state_ff == YAG_HOLD),
                        pending_ff, state_ff};

  // ****************************************
  // Bit insertion
  // ****************************************
  logic bit_out_ff;
  logic nxt_bit_out;
  logic bit_valid_ff;
  logic alarm_active_ff;
  logic nxt_alarm_active;
  logic esf_sending;

  assign esf_sending = (state_ff == YAG_SEND) | (state_ff == YAG_CONT);

  always_comb begin
    nxt_bit_out = bit_in;
    nxt_alarm_active = 1'b0;
    case (rai_format_select)
      `YAG_FMT_OFF: begin
        nxt_bit_out = bit_in;
      end
      `YAG_FMT_STD, `YAG_FMT_J1ESF: begin
        if ((framing == YAG_FR_SF || framing == YAG_FR_N)) begin
          nxt_alarm_active = 1'b1;
          if (ds0_bit2_slot) begin
            nxt_bit_out = 1'b0;
          end
        end else if (framing == YAG_FR_DM) begin
          nxt_alarm_active = 1'b1;
          if (dm_ybit_slot) begin
            nxt_bit_out = 1'b0;
          end
        end else begin
          nxt_alarm_active = esf_sending;
          if (fdl_slot && esf_sending) begin
            nxt_bit_out = pat_bit;
          end
        end
      end
      `YAG_FMT_ALT: begin
        if (framing == YAG_FR_SF) begin
          nxt_alarm_active = 1'b1;
          if (fs_frame12_slot) begin
            nxt_bit_out = 1'b1;
          end
        end else if (framing == YAG_FR_DM) begin
          nxt_alarm_active = 1'b1;
          if (dm_ybit_slot) begin
            nxt_bit_out = 1'b0;
          end
        end else if (framing == YAG_FR_ESF) begin
          nxt_alarm_active = esf_sending;
          if (fdl_slot && esf_sending) begin
            nxt_bit_out = pat_bit;
          end
        end
      end
      default: begin
        nxt_bit_out = bit_in;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_out_ff <= 1'b0;
      bit_valid_ff <= 1'b0;
      alarm_active_ff <= 1'b0;
    end else if (ce) begin
      bit_out_ff <= nxt_bit_out;
      bit_valid_ff <= bit_valid_in;
      alarm_active_ff <= nxt_alarm_active;
    end
  end

  assign bit_out = bit_out_ff;
  assign bit_valid_out = bit_valid_ff;
  assign alarm_active = alarm_active_ff;

endmodule
`default_nettype wire

// >>> yag_top_test.sv
// Self-checking bench for the remote alarm generator
`timescale 1ns/10ps
`default_nettype none

module yag_top_test
  import yag_pkg::*;
;
  localparam int HO = 50;
  localparam int NP = 3;
  localparam logic [31:0] AC = 32'h0000_0000;
  localparam logic [31:0] AS = 32'h0000_0004;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [3:0] slot = 4'h0;
  logic bvi = 1'b0;
  logic bin = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic bit_valid_out;
  logic bit_out;
  logic alarm_active;
  logic [15:0] rx_count;
  logic [31:0] r;
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int nbits = 0;
  int t0 = 0;
  always #2 clk = ~clk;
  yag_top #(.HOLDOFF_CYCLES(HO), .PATTERNS(NP)) uut (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .bit_valid_in(bvi), .bit_in(bin), .ds0_bit2_slot(slot[0]),
    .fs_frame12_slot(slot[1]), .fdl_slot(slot[2]), .dm_ybit_slot(slot[3]),
    .bit_valid_out(bit_valid_out), .bit_out(bit_out), .alarm_active(alarm_active));
  yag_line_model m_line (.clk(clk), .rst_b(rst_b), .bit_valid_out(bit_valid_out),
    .bit_out(bit_out), .rx_count(rx_count));
  // ********
  // Tasks
  // ********
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(logic w, logic [31:0] a, logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic rd(logic [31:0] a, logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(r, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  task automatic bitx(logic [3:0] s, logic b, logic e, logic ck);
    @(posedge clk);
    bvi <= 1'b1;
    slot <= s;
    bin <= b;
    @(posedge clk);
    bvi <= 1'b0;
    slot <= 4'h0;
    #1;
    nbits++;
    if (ck) begin
      chk({31'h0, bit_out}, {31'h0, e});
    end
  endtask
  // Mode 0 passes zeros, 1 half-ones pattern, 2 all ones, 3 unchecked
  task automatic esf(int n, int m);
    for (int k = 0; k < n; k++) begin
      bitx(4'h4, 1'b0, m == 2 || (m == 1 && k % 16 < 8), m != 3);
    end
  endtask
  task automatic wait_act(logic v);
    for (int i = 0; i < 200 && alarm_active !== v; i++) @(posedge clk);
    chk({31'h0, alarm_active}, {31'h0, v});
  endtask
  function automatic logic xp(int f, int c, int s, logic b);
    if (s == 0 && f != 3 && c % 2 == 1) return 1'b0;
    if (s == 2 && f == 3 && c != 0) return 1'b0;
    if (s == 1 && f == 0 && c == 2) return 1'b1;
    return b;
  endfunction
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      fail_count++;
      end_of_test();
    end
  end
  // ********
  // Main sequence
  // ********
  initial begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    rd(AC, 32'h0000_0000);
    xfer(1'b1, AS, 32'hFFFF_FFFF);
    rd(AS, 32'h0000_0000);
    xfer(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    rd(32'h0000_0010, 32'h0000_0000);
    xfer(1'b1, AC, 32'hFFFF_FF32);
    rd(AC, 32'h0000_0032);
    // Non-data-link insertion over SF, N and data-mode framing and every format code
    for (int f = 0; f < 4; f++) begin
      for (int c = 0; c < 4; c++) begin
        if (f == 1) continue;
        xfer(1'b1, AC, 32'(c * 16 + f));
        for (int s = 0; s < 3; s++) begin
          for (int b = 0; b < 2; b++) begin
            bitx(s == 2 ? 4'h8 : 4'(1 << s), b[0], xp(f, c, s, b[0]), 1'b1);
          end
        end
      end
    end
    xfer(1'b1, AC, 32'h0000_0051);
    xfer(1'b1, AC, 32'h0000_0011);
    wait_act(1'b1);
    esf(NP * 16, 1);
    t0 = cyc;
    rd(AS, 32'h0000_000B);
    esf(16, 0);
    xfer(1'b1, AC, 32'h0000_0051);
    wait_act(1'b1);
    chk(32'(cyc - t0 >= HO), 32'h0000_0001);
    esf(2 * NP * 16, 1);
    xfer(1'b1, AC, 32'h0000_0011);
    esf(NP * 16, 1);
    esf(16, 0);
    xfer(1'b1, AC, 32'h0000_0031);
    xfer(1'b1, AC, 32'h0000_0071);
    xfer(1'b1, AC, 32'h0000_0031);
    wait_act(1'b1);
    esf(NP * 16, 2);
    esf(32, 0);
    xfer(1'b1, AC, 32'h0000_0061);
    wait_act(1'b1);
    esf(64, 3);
    chk({31'h0, alarm_active}, 32'h0000_0001);
    xfer(1'b1, AC, 32'h0000_0021);
    repeat (4) @(posedge clk);
    chk({31'h0, alarm_active}, 32'h0000_0000);
    esf(16, 0);
    // The model counts the last bit one edge after it leaves the block
    repeat (2) @(posedge clk);
    chk({16'h0, rx_count}, 32'(nbits));
    end_of_test();
  end
endmodule

`default_nettype wire
